// *** dnn_slave_node.sv ***
// DeviceNet slave node: I/O connection producer and responder
//
// Summary of operation
// - Change-of-state producer sends on event.
// - Cyclic data sent with configured parameters.
// - Strobe reply sent at once, max 7 bytes.
// - Node address 0..63 matches master configuration.
// - Change-of-state also sends at heartbeat period.
// - Cyclic producer sends once per period.
// - Change-of-state waits inhibit time before send.
// - Unacknowledged message is sent again.
// - Retry limit reached puts connection in error.
// - Coupler strobe reply at most 7 bytes.
`timescale 1ns/1ps
`default_nettype none
module dnn_slave_node #(
  parameter int unsigned TICK_CYCLES = dnn_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [31:0] regRdata,
  input  wire logic        rxValid,
  input  wire logic [1:0]  rxKind,
  input  wire logic [5:0]  rxMacId,
  input  wire logic [63:0] rxData,
  output var  logic        txValid,
  input  wire logic        txReady,
  output var  logic [1:0]  txKind,
  output var  logic [5:0]  txMacId,
  output var  logic [3:0]  txLen,
  output var  logic [63:0] txData,
  output var  logic        ioError
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [5:0]  macId;
    logic [1:0]  mode;
    logic        enable;
    logic [15:0] period;
    logic [15:0] inhibit;
    logic [15:0] ackTmo;
    logic [7:0]  retryLim;
    logic [63:0] prod;
    logic [3:0]  prodLen;
    logic [63:0] cons;
    logic        strobeBit;
    logic [15:0] tickCnt;
    logic        tick;
    logic [15:0] perCnt;
    logic [15:0] inhCnt;
    logic [15:0] ackCnt;
    logic [7:0]  retries;
    logic        awaitAck;
    logic        dirty;
    logic        ioError;
    logic        reqPoll;
    logic        reqStrobe;
    logic        reqProd;
    logic        txValid;
    logic [1:0]  txKind;
    logic [3:0]  txLen;
    logic [63:0] txData;
    logic [31:0] rdata;
  } dnn_state_t;

  dnn_state_t state_reg;
  dnn_state_t state_next;

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    logic prodWrite;
    logic addrHit;
    logic produced;
    prodWrite  = 1'b0;
    addrHit    = rxMacId == state_reg.macId;
    produced   = state_reg.mode == dnn_pkg::MODE_COS ||
                 state_reg.mode == dnn_pkg::MODE_CYCLIC;
    state_next = state_reg;
    state_next.tick = 1'b0;

    // Millisecond tick
    if (state_reg.tickCnt == 16'(TICK_CYCLES - 1)) begin
      state_next.tickCnt = 16'h0000;
      state_next.tick    = 1'b1;
    end else begin
      state_next.tickCnt = state_reg.tickCnt + 16'h0001;
    end

    // Register writes; error clear comes first so a new error wins
    if (regWr) begin
      case (regAddr)
        dnn_pkg::OFS_CTRL: begin
          state_next.macId  = regWdata[dnn_pkg::CTRL_MAC_LSB +: 6];
          state_next.mode   = regWdata[dnn_pkg::CTRL_MODE_LSB +: 2];
          state_next.enable = regWdata[dnn_pkg::CTRL_EN_BIT];
          if (regWdata[dnn_pkg::CTRL_CLR_BIT]) begin
            state_next.ioError  = 1'b0;
            state_next.retries  = 8'h00;
            state_next.awaitAck = 1'b0;
          end
        end
        dnn_pkg::OFS_RATE: begin
          state_next.period  = regWdata[dnn_pkg::RATE_PER_LSB +: 16];
          state_next.inhibit = regWdata[dnn_pkg::RATE_INH_LSB +: 16];
        end
        dnn_pkg::OFS_ACK: begin
          state_next.ackTmo   = regWdata[dnn_pkg::ACK_TMO_LSB +: 16];
          state_next.retryLim = regWdata[dnn_pkg::ACK_LIM_LSB +: 8];
        end
        dnn_pkg::OFS_PROD_LO: begin
          state_next.prod[31:0] = regWdata;
          prodWrite = regWdata != state_reg.prod[31:0];
        end
        dnn_pkg::OFS_PROD_HI: begin
          state_next.prod[63:32] = regWdata;
          prodWrite = regWdata != state_reg.prod[63:32];
        end
        dnn_pkg::OFS_LEN: begin
          state_next.prodLen = (regWdata[3:0] > dnn_pkg::MAX_FRAME) ?
                               dnn_pkg::MAX_FRAME : regWdata[3:0];
        end
        default: ;
      endcase
    end

    // Read data, valid the cycle after the strobe
    state_next.rdata = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        dnn_pkg::OFS_CTRL:    state_next.rdata = {23'h00_0000,
                                state_reg.enable, state_reg.mode,
                                state_reg.macId};
        dnn_pkg::OFS_RATE:    state_next.rdata = {state_reg.inhibit,
                                                  state_reg.period};
        dnn_pkg::OFS_ACK:     state_next.rdata = {8'h00, state_reg.retryLim,
                                                  state_reg.ackTmo};
        dnn_pkg::OFS_PROD_LO: state_next.rdata = state_reg.prod[31:0];
        dnn_pkg::OFS_PROD_HI: state_next.rdata = state_reg.prod[63:32];
        dnn_pkg::OFS_CONS_LO: state_next.rdata = state_reg.cons[31:0];
        dnn_pkg::OFS_CONS_HI: state_next.rdata = state_reg.cons[63:32];
        dnn_pkg::OFS_STATUS:  state_next.rdata = {21'h00_0000,
                                state_reg.strobeBit, state_reg.retries,
                                state_reg.awaitAck, state_reg.ioError};
        dnn_pkg::OFS_LEN:     state_next.rdata = {28'h000_0000,
                                                  state_reg.prodLen};
        default:              state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Frames from the master
    if (rxValid && state_reg.enable) begin
      case (rxKind)
        dnn_pkg::KIND_POLL: begin
          if (addrHit) begin
            state_next.cons    = rxData;
            state_next.reqPoll = 1'b1;
          end
        end
        dnn_pkg::KIND_STROBE: begin
          state_next.strobeBit = rxData[state_reg.macId];
          state_next.reqStrobe = 1'b1;
        end
        dnn_pkg::KIND_ACK: begin
          if (addrHit && state_reg.awaitAck) begin
            state_next.awaitAck = 1'b0;
            state_next.retries  = 8'h00;
            state_next.reqProd  = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Millisecond timers
    if (state_reg.tick) begin
      if (state_reg.perCnt != 16'h0000)
        state_next.perCnt = state_reg.perCnt - 16'h0001;
      if (state_reg.inhCnt != 16'h0000)
        state_next.inhCnt = state_reg.inhCnt - 16'h0001;
      if (state_reg.ackCnt != 16'h0000 && state_reg.awaitAck)
        state_next.ackCnt = state_reg.ackCnt - 16'h0001;
    end

    // Production trigger for change-of-state and cyclic modes
    if (state_reg.enable && produced && !state_reg.ioError &&
        !state_reg.awaitAck && !state_reg.reqProd) begin
      if (state_reg.perCnt == 16'h0000) begin
        state_next.reqProd = 1'b1;
        state_next.perCnt  = state_reg.period;
        state_next.dirty   = 1'b0;
        state_next.inhCnt  = state_reg.inhibit;
      end else if (state_reg.mode == dnn_pkg::MODE_COS &&
                   state_reg.dirty &&
                   state_reg.inhCnt == 16'h0000) begin
        state_next.reqProd = 1'b1;
        state_next.perCnt  = state_reg.period;
        state_next.dirty   = 1'b0;
        state_next.inhCnt  = state_reg.inhibit;
      end
    end

    // Acknowledge timeout: resend or fall into error
    if (state_reg.awaitAck && !state_reg.reqProd &&
        state_reg.ackCnt == 16'h0000 &&
        !(rxValid && rxKind == dnn_pkg::KIND_ACK && addrHit)) begin
      if (state_reg.retries == state_reg.retryLim) begin
        state_next.ioError  = 1'b1;
        state_next.awaitAck = 1'b0;
      end else begin
        state_next.retries = state_reg.retries + 8'h01;
        state_next.reqProd = 1'b1;
      end
    end

    // A data change starts the inhibit wait; set beats clear
    if (prodWrite) begin
      state_next.dirty = 1'b1;
      if (!state_reg.dirty)
        state_next.inhCnt = state_reg.inhibit;
    end

    // Transmit slot: strobe reply first, then poll, then produced
    if (state_reg.txValid && txReady)
      state_next.txValid = 1'b0;
    if (!state_reg.txValid || txReady) begin
      if (state_reg.reqStrobe) begin
        state_next.reqStrobe = 1'b0;
        state_next.txValid   = 1'b1;
        state_next.txKind    = dnn_pkg::KIND_STROBE;
        state_next.txData    = state_reg.prod;
        state_next.txLen     = (state_reg.prodLen > dnn_pkg::MAX_STROBE) ?
                               dnn_pkg::MAX_STROBE : state_reg.prodLen;
      end else if (state_reg.reqPoll) begin
        state_next.reqPoll = 1'b0;
        state_next.txValid = 1'b1;
        state_next.txKind  = dnn_pkg::KIND_POLL;
        state_next.txData  = state_reg.prod;
        state_next.txLen   = state_reg.prodLen;
      end else if (state_reg.reqProd && state_next.reqProd) begin
        state_next.reqProd  = 1'b0;
        state_next.txValid  = 1'b1;
        state_next.txKind   = dnn_pkg::KIND_PROD;
        state_next.txData   = state_reg.prod;
        state_next.txLen    = state_reg.prodLen;
        state_next.awaitAck = 1'b1;
        state_next.ackCnt   = state_reg.ackTmo;
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg          <= '0;
      state_reg.mode     <= dnn_pkg::MODE_POLL;
      state_reg.period   <= dnn_pkg::RST_PERIOD;
      state_reg.inhibit  <= dnn_pkg::RST_INHIBIT;
      state_reg.ackTmo   <= dnn_pkg::RST_ACK_TMO;
      state_reg.retryLim <= dnn_pkg::RST_RETRY;
      state_reg.prodLen  <= dnn_pkg::RST_LEN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign regRdata = state_reg.rdata;
  assign txValid  = state_reg.txValid;
  assign txKind   = state_reg.txKind;
  assign txMacId  = state_reg.macId;
  assign txLen    = state_reg.txLen;
  assign txData   = state_reg.txData;
  assign ioError  = state_reg.ioError;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_strobe_len;
    txValid && txKind == dnn_pkg::KIND_STROBE |-> txLen <= 4'h7;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe reply longer than 7 bytes");

  property p_frame_len;
    txValid |-> txLen <= 4'h8;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("reply frame longer than 8 bytes");

  property p_strobe_now;
    rxValid && rxKind == dnn_pkg::KIND_STROBE && state_reg.enable &&
    !state_reg.txValid && !state_reg.reqStrobe
    |-> ##2 txValid && txKind == dnn_pkg::KIND_STROBE;
  endproperty
  a_strobe_now: assert property (p_strobe_now)
    else $error("strobe reply not sent two cycles after command");

  property p_ack_reset;
    rxValid && rxKind == dnn_pkg::KIND_ACK && state_reg.enable &&
    rxMacId == state_reg.macId && state_reg.awaitAck
    |=> state_reg.retries == 8'h00 && !state_reg.awaitAck;
  endproperty
  a_ack_reset: assert property (p_ack_reset)
    else $error("acknowledge did not reset retry count");

  property p_err_limit;
    $rose(ioError) |-> $past(state_reg.retries) == state_reg.retryLim;
  endproperty
  a_err_limit: assert property (p_err_limit)
    else $error("error entered before retry limit");

  property p_retry_step;
    state_reg.retries != $past(state_reg.retries) &&
    state_reg.retries != 8'h00
    |-> state_reg.retries == $past(state_reg.retries) + 8'h01;
  endproperty
  a_retry_step: assert property (p_retry_step)
    else $error("retry count did not step by one");

  property p_no_prod_err;
    ioError |=> !(txValid && !$past(txValid) &&
                  txKind == dnn_pkg::KIND_PROD);
  endproperty
  a_no_prod_err: assert property (p_no_prod_err)
    else $error("produced data sent in error state");

  property p_hold_tx;
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txKind);
  endproperty
  a_hold_tx: assert property (p_hold_tx)
    else $error("frame dropped while link stalled");

endmodule : dnn_slave_node
`default_nettype wire

// *** dnn_pkg.sv ***
// Constants and types shared by the DeviceNet slave node controller
`default_nettype none
package dnn_pkg;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RATE    = 8'h04;
  localparam logic [7:0] OFS_ACK     = 8'h08;
  localparam logic [7:0] OFS_PROD_LO = 8'h0C;
  localparam logic [7:0] OFS_PROD_HI = 8'h10;
  localparam logic [7:0] OFS_CONS_LO = 8'h14;
  localparam logic [7:0] OFS_CONS_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_LEN     = 8'h20;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTRL_MAC_LSB   = 0;  // Node address, 6 bits
  localparam int CTRL_MODE_LSB  = 6;  // I/O mode, 2 bits
  localparam int CTRL_EN_BIT    = 8;  // Node enable
  localparam int CTRL_CLR_BIT   = 9;  // Clear connection error, write 1
  localparam int RATE_PER_LSB   = 0;  // Heartbeat / send period, ms
  localparam int RATE_INH_LSB   = 16; // Inhibit time, ms
  localparam int ACK_TMO_LSB    = 0;  // Acknowledge timeout, ms
  localparam int ACK_LIM_LSB    = 16; // Retry limit, 8 bits
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_WAIT_BIT  = 1;
  localparam int STAT_RETRY_LSB = 2;
  localparam int STAT_STRB_BIT  = 10;

  // ***************************************************************
  // Reset values and limits
  // ***************************************************************
  localparam logic [15:0] RST_PERIOD  = 16'h0064;
  localparam logic [15:0] RST_INHIBIT = 16'h0000;
  localparam logic [15:0] RST_ACK_TMO = 16'h0010;
  localparam logic [7:0]  RST_RETRY   = 8'h03;
  localparam logic [3:0]  RST_LEN     = 4'h8;
  localparam logic [3:0]  MAX_FRAME   = 4'h8;  // Longest reply frame
  localparam logic [3:0]  MAX_STROBE  = 4'h7;  // Longest strobe reply

  // ***************************************************************
  // Timing: one timer tick of 1 ms at a 25 ns clock
  // ***************************************************************
  localparam int CLK_NS      = 25;
  localparam int TICK_NS     = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  // ***************************************************************
  // Enumerations
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_POLL   = 2'b00,
    MODE_COS    = 2'b01,
    MODE_CYCLIC = 2'b10,
    MODE_STROBE = 2'b11
  } dnn_mode_t;

  typedef enum logic [1:0] {
    KIND_POLL   = 2'b00,  // Poll request / poll reply
    KIND_STROBE = 2'b01,  // Bit strobe command / strobe reply
    KIND_ACK    = 2'b10,  // Acknowledge of produced data
    KIND_PROD   = 2'b11   // COS or cyclic produced data
  } dnn_kind_t;

endpackage : dnn_pkg
`default_nettype wire

// *** dnn_master_model.sv ***
// Behavioural DeviceNet master facing the slave node link
`timescale 1ns/1ps
`default_nettype none
module dnn_master_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reqGo,
  input  wire logic [1:0]  reqKind,
  input  wire logic [5:0]  reqMac,
  input  wire logic [63:0] reqData,
  input  wire logic        slow,
  output var  logic        rxValid,
  output var  logic [1:0]  rxKind,
  output var  logic [5:0]  rxMacId,
  output var  logic [63:0] rxData,
  input  wire logic        txValid,
  output var  logic        txReady,
  input  wire logic [1:0]  txKind,
  input  wire logic [5:0]  txMacId,
  input  wire logic [3:0]  txLen,
  input  wire logic [63:0] txData,
  output var  int          frameCnt,
  output var  logic [75:0] lastFrame,
  output var  logic        holdErr
);
  // ****************************
  // Master side of the link
  // ****************************
  logic [2:0]  bootCnt;
  logic [1:0]  slowCnt;
  logic        pend;
  logic [75:0] held;
  logic [75:0] cur;

  assign cur = {txKind, txMacId, txLen, txData};

  // Requests out; a startup phase of 7 cycles comes first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bootCnt <= 3'h0;
      rxValid <= 1'b0;
      rxKind  <= 2'h0;
      rxMacId <= 6'h00;
      rxData  <= 64'h0;
    end else begin
      if (bootCnt != 3'h7) begin
        bootCnt <= bootCnt + 3'h1;  // Startup phase
      end
      rxValid <= reqGo && (bootCnt == 3'h7);  // No I/O before
      if (reqGo) begin
        rxKind  <= reqKind;  // Poll, strobe, ack per cycle
        rxMacId <= reqMac;
        rxData  <= reqData;  // Bit n for node n
      end else begin
        rxKind  <= ~rxKind;  // Released lines toggle
        rxMacId <= ~rxMacId;
        rxData  <= ~rxData;
      end
    end
  end

  // Frame acceptance, prompt or slowed, with hold check
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slowCnt   <= 2'h0;
      txReady   <= 1'b0;
      pend      <= 1'b0;
      held      <= 76'h0;
      frameCnt  <= 0;
      lastFrame <= 76'h0;
      holdErr   <= 1'b0;
    end else begin
      slowCnt <= slowCnt + 2'h1;
      txReady <= !slow || (slowCnt == 2'h2);
      if (txValid && txReady) begin
        frameCnt  <= frameCnt + 1;
        lastFrame <= cur;  // Any length 0..8 taken
      end
      if (pend && (!txValid || cur != held)) begin
        holdErr <= 1'b1;
      end
      pend <= txValid && !txReady;
      held <= cur;
    end
  end
endmodule : dnn_master_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the DeviceNet slave node
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [5:0]  MAC  = 6'h05;
  localparam logic [63:0] PROD = 64'h1122_3344_5566_7788;
  logic        clk, arst_n, regWr, regRd, rxValid, txValid, txReady;
  logic        ioError, reqGo, slow, holdErr;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0]  rxKind, txKind, reqKind;
  logic [5:0]  rxMacId, txMacId, reqMac;
  logic [63:0] rxData, txData, reqData;
  logic [3:0]  txLen;
  logic [75:0] lastFrame;
  int          frameCnt, cyc, stamp, nFail, nCompared;

  dnn_slave_node #(.TICK_CYCLES(4)) dut (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxValid(rxValid),
    .rxKind(rxKind), .rxMacId(rxMacId), .rxData(rxData),
    .txValid(txValid), .txReady(txReady), .txKind(txKind),
    .txMacId(txMacId), .txLen(txLen), .txData(txData), .ioError(ioError));
  dnn_master_model master (
    .clk(clk), .arst_n(arst_n), .reqGo(reqGo), .reqKind(reqKind),
    .reqMac(reqMac), .reqData(reqData), .slow(slow), .rxValid(rxValid),
    .rxKind(rxKind), .rxMacId(rxMacId), .rxData(rxData),
    .txValid(txValid), .txReady(txReady), .txKind(txKind),
    .txMacId(txMacId), .txLen(txLen), .txData(txData),
    .frameCnt(frameCnt), .lastFrame(lastFrame), .holdErr(holdErr));

  // ****************************
  // Clock, ceiling and helpers
  // ****************************
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nFail = nFail + 1;
      finishTest();
    end
  end

  task automatic finishTest();
    $display("counts: compared %0d failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finishTest

  task automatic chk(string name, logic [79:0] exp, logic [79:0] got);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Register port cycles
  task automatic regWrite(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic expRd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, regRdata);
  endtask : expRd

  // Master requests and frame checks
  task automatic send(logic [1:0] k, logic [5:0] m, logic [63:0] d);
    @(posedge clk);
    reqGo   <= 1'b1;
    reqKind <= k;
    reqMac  <= m;
    reqData <= d;
    @(posedge clk);
    reqGo <= 1'b0;
  endtask : send

  task automatic expFrame(logic [11:0] h, logic [63:0] d, int lim, bit full);
    int n0;
    n0 = frameCnt;
    for (int i = 0; i < lim && frameCnt == n0; i++) begin
      @(posedge clk);
      #1;
    end
    stamp = cyc;
    chk("frame count", n0 + 1, frameCnt);
    chk("frame head", h, lastFrame[75:64]);
    if (full) chk("frame data", d, lastFrame[63:0]);
  endtask : expFrame

  task automatic noFrame(int lim);
    int n0;
    n0 = frameCnt;
    repeat (lim) @(posedge clk);
    #1 chk("no frame", n0, frameCnt);
  endtask : noFrame

  function automatic logic [31:0] ctrlW(logic [1:0] m, logic clr);
    return {22'h0, clr, 1'b1, m, MAC};
  endfunction : ctrlW

  task automatic doReset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : doReset

  // ****************************
  // Scenarios
  // ****************************
  task automatic tReset();
    expRd(dnn_pkg::OFS_CTRL, 32'h0000_0000);
    expRd(dnn_pkg::OFS_RATE, 32'h0000_0064);
    expRd(dnn_pkg::OFS_ACK, 32'h0003_0010);
    expRd(dnn_pkg::OFS_LEN, 32'h0000_0008);
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0000);
    expRd(8'h24, 32'h0000_0000);
    send(dnn_pkg::KIND_POLL, 6'h00, PROD);
    noFrame(20);
  endtask : tReset

  task automatic tPoll();
    logic [63:0] o;
    o = 64'hA5A5_0000_FFFF_1234;
    regWrite(dnn_pkg::OFS_PROD_LO, PROD[31:0]);
    regWrite(dnn_pkg::OFS_PROD_HI, PROD[63:32]);
    regWrite(dnn_pkg::OFS_CTRL, ctrlW(dnn_pkg::MODE_POLL, 1'b0));
    send(dnn_pkg::KIND_POLL, MAC, o);
    expFrame({2'h0, MAC, 4'h8}, PROD, 20, 1'b1);
    expRd(dnn_pkg::OFS_CONS_LO, o[31:0]);
    expRd(dnn_pkg::OFS_CONS_HI, o[63:32]);
    send(dnn_pkg::KIND_POLL, MAC ^ 6'h01, o);
    noFrame(20);
    regWrite(dnn_pkg::OFS_LEN, 32'h0000_0000);
    send(dnn_pkg::KIND_POLL, MAC, o);
    expFrame({2'h0, MAC, 4'h0}, PROD, 20, 1'b0);
    regWrite(dnn_pkg::OFS_LEN, 32'h0000_000F);
    expRd(dnn_pkg::OFS_LEN, 32'h0000_0008);
  endtask : tPoll

  task automatic tCos();
    logic [31:0] hi;
    int          t0;
    hi = PROD[63:32];
    regWrite(dnn_pkg::OFS_PROD_HI, hi);
    regWrite(dnn_pkg::OFS_ACK, 32'h0002_0001);
    regWrite(dnn_pkg::OFS_PROD_LO, 32'h0000_0001);
    // Idle period counter sends a heartbeat as soon as enabled
    regWrite(dnn_pkg::OFS_CTRL, ctrlW(dnn_pkg::MODE_COS, 1'b0));
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h1}, 40, 1'b1);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h1}, 40, 1'b1);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h1}, 40, 1'b1);
    for (int i = 0; i < 40 && ioError !== 1'b1; i++) @(posedge clk);
    #1 chk("io error", 1'b1, ioError);
    noFrame(40);
    regWrite(dnn_pkg::OFS_CTRL, ctrlW(dnn_pkg::MODE_COS, 1'b1));
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0000);
    regWrite(dnn_pkg::OFS_ACK, 32'h0002_0004);
    regWrite(dnn_pkg::OFS_PROD_LO, 32'h0000_0002);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h2}, 40, 1'b1);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h2}, 40, 1'b1);
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0006);
    send(dnn_pkg::KIND_ACK, MAC, 64'h0);
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0000);
    regWrite(dnn_pkg::OFS_RATE, 32'h0005_0064);
    regWrite(dnn_pkg::OFS_PROD_LO, 32'h0000_0003);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h3}, 60, 1'b1);
    t0 = stamp;
    send(dnn_pkg::KIND_ACK, MAC, 64'h0);
    regWrite(dnn_pkg::OFS_PROD_LO, 32'h0000_0004);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h4}, 60, 1'b1);
    chk("inhibit gap", 1'b1, stamp - t0 >= 16);
    send(dnn_pkg::KIND_ACK, MAC, 64'h0);
    expFrame({2'h3, MAC, 4'h8}, {hi, 32'h4}, 450, 1'b1);
    send(dnn_pkg::KIND_ACK, MAC, 64'h0);
  endtask : tCos

  task automatic tCyclic();
    int t0;
    regWrite(dnn_pkg::OFS_RATE, 32'h0000_000A);
    regWrite(dnn_pkg::OFS_CTRL, ctrlW(dnn_pkg::MODE_CYCLIC, 1'b0));
    expFrame({2'h3, MAC, 4'h8}, 64'h0, 450, 1'b0);
    t0 = stamp;
    send(dnn_pkg::KIND_ACK, MAC, 64'h0);
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0000);
    expFrame({2'h3, MAC, 4'h8}, 64'h0, 60, 1'b0);
    chk("send gap", 1'b1, stamp - t0 >= 32 && stamp - t0 <= 48);
    send(dnn_pkg::KIND_ACK, MAC, 64'h0);
  endtask : tCyclic

  task automatic tStrobe();
    slow <= 1'b1;
    regWrite(dnn_pkg::OFS_CTRL, ctrlW(dnn_pkg::MODE_STROBE, 1'b0));
    send(dnn_pkg::KIND_STROBE, 6'h00, 64'h1 << MAC);
    expFrame({2'h1, MAC, 4'h7}, 64'h0, 40, 1'b0);
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0400);
    send(dnn_pkg::KIND_STROBE, 6'h3F, ~(64'h1 << MAC));
    expFrame({2'h1, MAC, 4'h7}, 64'h0, 40, 1'b0);
    expRd(dnn_pkg::OFS_STATUS, 32'h0000_0000);
    chk("held frame", 1'b0, holdErr);
    slow <= 1'b0;
  endtask : tStrobe

  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {regWr, regRd, reqGo, slow} = 4'h0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    {reqKind, reqMac, reqData} = 72'h0;
    {cyc, nFail, nCompared, stamp} = 128'h0;
    doReset();
    tReset();
    tPoll();
    doReset();
    tCos();
    tCyclic();
    tStrobe();
    finishTest();
  end
endmodule : tb_top
`default_nettype wire
